// ==== rtl/sfc_pkg.sv ====
/*
  Shared constants, command encodings, carrier structs and the command
  decoder of the serial flash command host.
  Assumes a 200 MHz system clock and a serial NOR flash on CS#, SCLK and
  four two-way data lines.
*/
package sfc_pkg;

  // Instruction opcodes.
  localparam logic [7:0] SFC_SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] SFC_CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] SFC_READ_IDENT_CMD        = 8'h9f;
  localparam logic [7:0] SFC_READ_STATUS_CMD       = 8'h05;
  localparam logic [7:0] SFC_WRITE_STATUS_CMD      = 8'h01;
  localparam logic [7:0] SFC_SINGLE_LINE_DDR_READ  = 8'h0d;
  localparam logic [7:0] SFC_DUAL_LINE_DDR_READ    = 8'hbd;
  localparam logic [7:0] SFC_QUAD_LINE_DDR_READ    = 8'hed;
  localparam logic [7:0] SFC_SECTOR_ERASE_CMD      = 8'h20;
  localparam logic [7:0] SFC_BLOCK_ERASE_CMD       = 8'hd8;

  // Phase lengths in SCLK cycles, identification byte count and status busy bit.
  localparam logic [4:0] SFC_OP_CYC        = 5'h08;
  localparam logic [4:0] SFC_WDATA_CYC     = 5'h08;
  localparam logic [4:0] SFC_ADDR_CYC_SDR  = 5'h18;
  localparam logic [4:0] SFC_ADDR_CYC_DDR1 = 5'h0c;
  localparam logic [4:0] SFC_ADDR_CYC_DDR2 = 5'h06;
  localparam logic [4:0] SFC_ADDR_CYC_DDR4 = 5'h03;
  localparam logic [4:0] SFC_DUMMY_DDR1    = 5'h06;
  localparam logic [4:0] SFC_DUMMY_DDR2    = 5'h06;
  localparam logic [4:0] SFC_MODE_DDR4     = 5'h01;
  localparam logic [4:0] SFC_WAIT_DDR4     = 5'h07;
  localparam logic [15:0] SFC_IDENT_BYTES  = 16'h0003;
  localparam int          SFC_BUSY_BIT     = 0;

  // Timing: system clock and least chip-select high time.
  localparam int SFC_CLK_PERIOD_PS = 5000;
  localparam int SFC_CS_HIGH_NS    = 50;
  localparam int SFC_CS_HIGH_CYC   = (SFC_CS_HIGH_NS * 1000 + SFC_CLK_PERIOD_PS - 1) / SFC_CLK_PERIOD_PS;
  localparam int SFC_SCLK_HALF_CYC = 8;
  localparam int SFC_FIFO_DEPTH    = 32;

  // Commands the user may request.
  typedef enum logic [3:0] {
    SFC_K_SET_WEL,
    SFC_K_CLR_WEL,
    SFC_K_IDENT,
    SFC_K_STATUS,
    SFC_K_WR_STATUS,
    SFC_K_DDR1,
    SFC_K_DDR2,
    SFC_K_DDR4,
    SFC_K_SECT_ERASE,
    SFC_K_BLK_ERASE
  } sfc_kind_t;

  // One user request.
  typedef struct packed {
    sfc_kind_t   kind;
    logic        mode3;
    logic        poll_first;
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic [15:0] nbytes;
  } sfc_cmd_t;

  // Frame shape of one instruction.
  typedef struct packed {
    logic [7:0] opcode;
    logic [4:0] addr_cyc;
    logic [2:0] lanes;
    logic       ddr;
    logic [4:0] dummy_cyc;
    logic [4:0] mode_cyc;
    logic       wdata;
    logic       rdata;
    logic       ident;
  } sfc_plan_t;

  // Maps a request kind to its frame shape.
  function automatic sfc_plan_t sfc_decode(input sfc_kind_t kind);
    sfc_plan_t p;
    p = '0;
    p.lanes = 3'h1;
    case (kind)
      SFC_K_SET_WEL:   p.opcode = SFC_SET_WRITE_LATCH_CMD;
      SFC_K_CLR_WEL:   p.opcode = SFC_CLEAR_WRITE_LATCH_CMD;
      SFC_K_IDENT:
      begin
        p.opcode = SFC_READ_IDENT_CMD;
        p.rdata  = 1'b1;
        p.ident  = 1'b1;
      end
      SFC_K_STATUS:
      begin
        p.opcode = SFC_READ_STATUS_CMD;
        p.rdata  = 1'b1;
      end
      SFC_K_WR_STATUS:
      begin
        p.opcode = SFC_WRITE_STATUS_CMD;
        p.wdata  = 1'b1;
      end
      SFC_K_DDR1:
      begin
        p.opcode    = SFC_SINGLE_LINE_DDR_READ;
        p.addr_cyc  = SFC_ADDR_CYC_DDR1;
        p.ddr       = 1'b1;
        p.dummy_cyc = SFC_DUMMY_DDR1;
        p.rdata     = 1'b1;
      end
      SFC_K_DDR2:
      begin
        p.opcode    = SFC_DUAL_LINE_DDR_READ;
        p.addr_cyc  = SFC_ADDR_CYC_DDR2;
        p.lanes     = 3'h2;
        p.ddr       = 1'b1;
        p.dummy_cyc = SFC_DUMMY_DDR2;
        p.rdata     = 1'b1;
      end
      SFC_K_DDR4:
      begin
        p.opcode    = SFC_QUAD_LINE_DDR_READ;
        p.addr_cyc  = SFC_ADDR_CYC_DDR4;
        p.lanes     = 3'h4;
        p.ddr       = 1'b1;
        p.mode_cyc  = SFC_MODE_DDR4;
        p.dummy_cyc = SFC_MODE_DDR4 + SFC_WAIT_DDR4;
        p.rdata     = 1'b1;
      end
      SFC_K_SECT_ERASE:
      begin
        p.opcode   = SFC_SECTOR_ERASE_CMD;
        p.addr_cyc = SFC_ADDR_CYC_SDR;
      end
      SFC_K_BLK_ERASE:
      begin
        p.opcode   = SFC_BLOCK_ERASE_CMD;
        p.addr_cyc = SFC_ADDR_CYC_SDR;
      end
      default:         p.opcode = SFC_READ_STATUS_CMD;
    endcase
    return p;
  endfunction

endpackage

// ==== rtl/sfc_sync.sv ====
/*
  Two-flop synchroniser for a bus of independent levels.
  Assumes each bit may change at any time relative to i_clk.
*/
`timescale 1ns/1ps
module sfc_sync
  import sfc_pkg::*;
#(
  parameter int W = 4
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// ==== rtl/sfc_fifo.sv ====
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module sfc_fifo
  import sfc_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = SFC_FIFO_DEPTH
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  // Full when the pointers differ only in the wrap bit.
  assign o_in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign o_out_valid = (wr_q != rd_q);
  assign o_out_data  = mem_q[rd_q[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage array.
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// ==== rtl/sfc_host.sv ====
/*
  Serial flash command host: takes one request at a time, frames it on
  CS#, SCLK and four two-way data lines, and streams read bytes out
  through a FIFO. SCLK is made here by dividing i_clk.
  Assumes a flash that samples and launches on the SCLK edges of the
  chosen rate, and a user that drains the read stream at its own pace.
*/
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
#(
  parameter int HALF_DIV = SFC_SCLK_HALF_CYC,
  parameter int CS_GAP   = SFC_CS_HIGH_CYC,
  parameter int DEPTH    = SFC_FIFO_DEPTH
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cmd_valid,
  output logic            o_cmd_ready,
  input  wire sfc_cmd_t   i_cmd,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_status,
  output logic            o_rd_valid,
  input  wire logic       i_rd_ready,
  output logic [7:0]      o_rd_data,
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic [3:0]      o_io_out,
  output logic [3:0]      o_io_oe,
  input  wire logic [3:0] i_io_in
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_LEAD,
    ST_OP,
    ST_ADDR,
    ST_DUMMY,
    ST_WDATA,
    ST_RDATA,
    ST_TAIL,
    ST_GAP
  } sfc_st_t;

  sfc_st_t     state_q;
  sfc_st_t     nxt_st;
  sfc_cmd_t    cmd_q;
  sfc_plan_t   plan_q;
  logic        polling_q;
  logic [7:0]  div_q;
  logic        half_q;
  logic [5:0]  left_q;
  logic [5:0]  nxt_left;
  logic [23:0] sh_q;
  logic [7:0]  rd_sh_q;
  logic [3:0]  rd_bits_q;
  logic [15:0] bytes_q;
  logic        last_q;
  logic [7:0]  gap_q;
  logic        cs_n_q;
  logic        sclk_q;
  logic [3:0]  io_out_q;
  logic [3:0]  io_oe_q;
  logic        done_q;
  logic [7:0]  status_q;
  logic [3:0]  io_s;
  logic        fifo_ready;
  logic        stall;
  logic        tick;
  logic        ddr_ph;
  logic        active;
  logic [2:0]  lanes;
  logic        sample;
  logic [3:0]  bits_new;
  logic        byte_now;
  logic [7:0]  byte_new;
  logic [15:0] total;
  logic        phase_end;

  // Data lines are sampled through a synchroniser.
  sfc_sync #(
    .W (4)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_io_in),
    .o_sync  (io_s)
  );

  // Read bytes wait here; a full FIFO stretches SCLK.
  sfc_fifo #(
    .W     (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (byte_now && !polling_q),
    .o_in_ready  (fifo_ready),
    .i_in_data   (byte_new),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

  // Half-period timing and per-phase line use.
  assign stall  = (state_q == ST_RDATA) && !polling_q && !fifo_ready;
  assign tick   = (div_q == 8'(HALF_DIV - 1)) && !stall;
  assign ddr_ph = plan_q.ddr && (state_q inside {ST_ADDR, ST_DUMMY, ST_RDATA});
  assign active = ddr_ph || !half_q;
  assign lanes  = (state_q inside {ST_ADDR, ST_DUMMY, ST_RDATA}) ? plan_q.lanes : 3'h1;
  assign sample = tick && active && (state_q == ST_RDATA);
  assign total  = plan_q.ident ? SFC_IDENT_BYTES : (polling_q || cmd_q.nbytes == 16'h0000) ? 16'h0001
                                                                                            : cmd_q.nbytes;

  // Input bits gather most significant first into a byte.
  always_comb
  begin
    bits_new = rd_bits_q + 4'(lanes);
    byte_now = sample && (bits_new == 4'h8);
    case (lanes)
      3'h2:    byte_new = {rd_sh_q[5:0], io_s[1:0]};
      3'h4:    byte_new = {rd_sh_q[3:0], io_s[3:0]};
      default: byte_new = {rd_sh_q[6:0], io_s[1]};
    endcase
  end

  // An SDR read frame closes on the half after its final byte, a DDR one on the half of it; others on count.
  assign phase_end = tick && ((state_q == ST_RDATA)
                              ? (ddr_ph ? (byte_now && bytes_q + 16'h0001 == total) : (half_q && last_q))
                              : (left_q == 6'h00));

  // Picks the phase that follows the current one and its length in halves.
  always_comb
  begin
    nxt_st   = ST_TAIL;
    nxt_left = 6'h00;
    case (state_q)
      ST_OP:
      begin
        if (plan_q.addr_cyc != 5'h00)
        begin
          nxt_st   = ST_ADDR;
          nxt_left = {plan_q.addr_cyc, 1'b0} - 6'h01;
        end
        else if (plan_q.wdata)
        begin
          nxt_st   = ST_WDATA;
          nxt_left = {SFC_WDATA_CYC, 1'b0} - 6'h01;
        end
        else if (plan_q.rdata)
        begin
          nxt_st = ST_RDATA;
        end
      end
      ST_ADDR:
      begin
        if (plan_q.dummy_cyc != 5'h00)
        begin
          nxt_st   = ST_DUMMY;
          nxt_left = {plan_q.dummy_cyc, 1'b0} - 6'h01;
        end
        else if (plan_q.rdata)
        begin
          nxt_st = ST_RDATA;
        end
      end
      ST_DUMMY: nxt_st = ST_RDATA;
      default:  nxt_st = ST_TAIL;
    endcase
  end

  // Frame sequencer.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q   <= ST_IDLE;
      cmd_q     <= '0;
      plan_q    <= '0;
      polling_q <= 1'b0;
      left_q    <= 6'h00;
      gap_q     <= 8'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (i_cmd_valid)
          begin
            cmd_q     <= i_cmd;
            polling_q <= i_cmd.poll_first && (i_cmd.kind != SFC_K_STATUS);
            plan_q    <= (i_cmd.poll_first && i_cmd.kind != SFC_K_STATUS) ? sfc_decode(SFC_K_STATUS)
                                                                          : sfc_decode(i_cmd.kind);
            state_q   <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          if (tick)
          begin
            state_q <= ST_OP;
            left_q  <= {SFC_OP_CYC, 1'b0} - 6'h01;
          end
        end
        ST_OP, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA:
        begin
          if (phase_end)
          begin
            state_q <= nxt_st;
            left_q  <= nxt_left;
          end
          else if (tick)
          begin
            left_q <= left_q - 6'h01;
          end
        end
        ST_TAIL:
        begin
          if (tick)
          begin
            state_q <= ST_GAP;
            gap_q   <= 8'(CS_GAP - 1);
          end
        end
        ST_GAP:
        begin
          if (gap_q == 8'h00)
          begin
            // A busy flash is polled again; a ready one gets the real request.
            if (polling_q && !status_q[SFC_BUSY_BIT])
            begin
              polling_q <= 1'b0;
              plan_q    <= sfc_decode(cmd_q.kind);
              state_q   <= ST_LEAD;
            end
            else
            begin
              state_q <= polling_q ? ST_LEAD : ST_IDLE;
            end
          end
          else
          begin
            gap_q <= gap_q - 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Half-period divider; SCLK toggles at each half boundary inside a frame.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      div_q  <= 8'h00;
      half_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else if (state_q == ST_IDLE || state_q == ST_GAP)
    begin
      div_q  <= 8'h00;
      half_q <= 1'b0;
      sclk_q <= (state_q == ST_IDLE && i_cmd_valid) ? i_cmd.mode3 : cmd_q.mode3;
    end
    else if (tick)
    begin
      div_q <= 8'h00;
      if (state_q == ST_LEAD)
      begin
        half_q <= 1'b0;
        sclk_q <= 1'b0;
      end
      else if (phase_end && nxt_st == ST_TAIL)
      begin
        sclk_q <= cmd_q.mode3;
      end
      else if (state_q != ST_TAIL)
      begin
        half_q <= !half_q;
        sclk_q <= !half_q;
      end
    end
    else if (!stall)
    begin
      div_q <= div_q + 8'h01;
    end
  end

  // Chip select falls after SCLK reaches its idle level and rises after the tail half.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cs_n_q <= 1'b1;
    end
    else if (state_q inside {ST_IDLE, ST_LEAD})
    begin
      cs_n_q <= (state_q == ST_IDLE);
    end
    else if (state_q == ST_GAP)
    begin
      cs_n_q <= !(gap_q == 8'h00 && polling_q);
    end
    else if (state_q == ST_TAIL && tick)
    begin
      cs_n_q <= 1'b1;
    end
  end

  // Outgoing shifter and line drive, refreshed at the start of each active half.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sh_q     <= 24'h000000;
      io_out_q <= 4'hc;
      io_oe_q  <= 4'hd;
    end
    else if (state_q == ST_LEAD && tick)
    begin
      sh_q <= {plan_q.opcode, 16'h0000};
    end
    else if (state_q == ST_OP && phase_end && nxt_st == ST_ADDR)
    begin
      sh_q <= cmd_q.addr;
    end
    else if (state_q == ST_OP && phase_end && nxt_st == ST_WDATA)
    begin
      sh_q <= {cmd_q.wdata, 16'h0000};
    end
    else if (div_q == 8'h00)
    begin
      case (state_q)
        ST_OP, ST_ADDR, ST_WDATA:
        begin
          if (active)
          begin
            // New bits appear just after the launching edge, MSB first.
            case (lanes)
              3'h2:    io_out_q <= {2'b11, sh_q[23:22]};
              3'h4:    io_out_q <= sh_q[23:20];
              default: io_out_q <= {3'b110, sh_q[23]};
            endcase
            io_oe_q <= (lanes == 3'h1) ? 4'hd : 4'hf;
            sh_q    <= sh_q << lanes;
          end
        end
        ST_DUMMY:
        begin
          // The first quad dummy cycle carries all-zero mode bits.
          if (lanes == 3'h4 && left_q > ({plan_q.dummy_cyc - plan_q.mode_cyc, 1'b0} - 6'h01))
          begin
            io_out_q <= 4'h0;
            io_oe_q  <= 4'hf;
          end
          else
          begin
            io_out_q <= 4'hc;
            io_oe_q  <= (lanes == 3'h4) ? 4'h0 : 4'hc;
          end
        end
        ST_RDATA:
        begin
          io_out_q <= 4'hc;
          io_oe_q  <= (lanes == 3'h4) ? 4'h0 : 4'hc;
        end
        default:
        begin
          io_out_q <= 4'hc;
          io_oe_q  <= 4'hd;
        end
      endcase
    end
  end

  // Incoming byte assembly, byte count and status capture.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rd_sh_q   <= 8'h00;
      rd_bits_q <= 4'h0;
      bytes_q   <= 16'h0000;
      last_q    <= 1'b0;
      status_q  <= 8'h00;
    end
    else if (state_q == ST_LEAD)
    begin
      rd_bits_q <= 4'h0;
      bytes_q   <= 16'h0000;
      last_q    <= 1'b0;
    end
    else if (sample)
    begin
      rd_sh_q   <= byte_new;
      rd_bits_q <= byte_now ? 4'h0 : bits_new;
      if (byte_now)
      begin
        bytes_q <= bytes_q + 16'h0001;
        last_q  <= (bytes_q + 16'h0001 == total);
        if (plan_q.opcode == SFC_READ_STATUS_CMD)
        begin
          status_q <= byte_new;
        end
      end
    end
  end

  // One-cycle completion pulse when a request's frame has fully closed.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == ST_GAP) && (gap_q == 8'h00) && !polling_q;
    end
  end

  assign o_cmd_ready = (state_q == ST_IDLE);
  assign o_busy      = (state_q != ST_IDLE);
  assign o_done      = done_q;
  assign o_status    = status_q;
  assign o_cs_n      = cs_n_q;
  assign o_sclk      = sclk_q;
  assign o_io_out    = io_out_q;
  assign o_io_oe     = io_oe_q;

endmodule

// ==== tb/sfc_host_monitor.sv ====
/*
  Checker of the serial flash command host, bound to its ports.
  Assumes the bench builds the host with HALF_DIV 4 and CS_GAP 2.
*/
`timescale 1ns/1ps
module sfc_host_monitor
  import sfc_pkg::*;
#(
  parameter int HALF_DIV = SFC_SCLK_HALF_CYC,
  parameter int CS_GAP   = SFC_CS_HIGH_CYC
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cmd_valid,
  input  wire logic       o_cmd_ready,
  input  wire sfc_cmd_t   i_cmd,
  input  wire logic       o_busy,
  input  wire logic       o_done,
  input  wire logic       o_rd_valid,
  input  wire logic       i_rd_ready,
  input  wire logic [7:0] o_rd_data,
  input  wire logic       o_cs_n,
  input  wire logic       o_sclk,
  input  wire logic [3:0] o_io_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Frame timing on the select and clock lines.
  property p_cs_gap;
    $rose(o_cs_n) |-> o_cs_n [*2];
  endproperty
  property p_take;
    i_cmd_valid && o_cmd_ready |=> o_busy ##1 !o_cs_n;
  endproperty
  property p_sclk_still;
    o_cs_n && $past(o_cs_n) && o_busy && $past(o_busy) |-> $stable(o_sclk);
  endproperty
  property p_half;
    !o_cs_n && $changed(o_sclk) |=> $stable(o_sclk) [*3];
  endproperty
  property p_first_line;
    $fell(o_cs_n) |-> o_io_oe[0] && !o_io_oe[1];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  a_take: assert property (p_take) else $error("accepted request opened no frame");
  a_sclk_still: assert property (p_sclk_still) else $error("clock moved while deselected");
  a_half: assert property (p_half) else $error("clock half too short");
  a_first_line: assert property (p_first_line) else $error("opcode not on one line");

  // Request port, completion and read stream.
  property p_ready;
    o_busy |-> !o_cmd_ready;
  endproperty
  property p_idle_lines;
    o_cs_n && $past(o_cs_n) && !o_busy |-> o_io_oe == 4'hd;
  endproperty
  property p_done;
    o_done |-> o_cs_n && $past(o_cs_n, 2) ##1 !o_done;
  endproperty
  property p_rd_hold;
    o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data);
  endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  a_idle_lines: assert property (p_idle_lines) else $error("idle line drive wrong");
  a_done: assert property (p_done) else $error("done outside the gap");
  a_rd_hold: assert property (p_rd_hold) else $error("read byte dropped");

  c_quad: cover property (i_cmd_valid && o_cmd_ready && i_cmd.kind == SFC_K_DDR4);
  c_done: cover property (o_done);
  c_stall: cover property (o_rd_valid && !i_rd_ready [*3]);
endmodule

bind sfc_host sfc_host_monitor #(.HALF_DIV(HALF_DIV), .CS_GAP(CS_GAP)) u_mon (.*);

// ==== tb/sfc_flash_model.sv ====
/*
  Behavioural serial NOR flash driven from its pins by the host.
  Assumes the bench resolves the four data lines with pull-ups.
*/
`timescale 1ns/1ps
module sfc_flash_model
  import sfc_pkg::*;
#(
  parameter logic [23:0] ID    = 24'h5a3c18, // Arbitrary identification value.
  parameter int          BUSYN = 3
)
(
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic [3:0] i_io,
  output logic      [3:0] o_io,
  output logic      [3:0] o_oe
);
  logic [7:0]  op;
  logic [7:0]  wd;
  logic [23:0] ad;
  logic [7:0]  by;
  logic [5:0]  sr   = '0;
  logic        write_enable_latch  = 1'b0;
  int          busy = 0;
  int          c;
  int          h;
  int          l;
  int          a;
  int          j;

  initial o_oe = '0;

  // Selection starts a fresh frame with every line released.
  always @(negedge i_cs_n)
  begin
    c = 0;
    op = '0;
    ad = '0;
    o_oe = '0;
  end

  // Each clock edge closes one half cycle; rising edges count cycles.
  always @(i_sclk)
  if (!i_cs_n)
  begin
    c = c + (i_sclk ? 1 : 0);
    h = i_sclk ? 2 * c - 2 : 2 * c - 1;
    l = op == SFC_QUAD_LINE_DDR_READ ? 4 : op == SFC_DUAL_LINE_DDR_READ ? 2 : 1;
    a = 16 + 24 / l;
    j = h - a - (op == SFC_QUAD_LINE_DDR_READ ? 15 : 11);
    if (c <= 8 && i_sclk)
      op = {op[6:0], i_io[0]};
    else if (op == SFC_WRITE_STATUS_CMD && i_sclk && c <= 16)
      wd = {wd[6:0], i_io[0]};
    else if ((op == SFC_READ_STATUS_CMD || op == SFC_READ_IDENT_CMD) && !i_sclk && h >= 15)
    begin
      by = op == SFC_READ_STATUS_CMD ? {sr, write_enable_latch, busy > 0} : 8'(ID >> (16 - 8 * ((h - 15) / 16 % 3)));
      o_io = {2'h0, by[7 - (h - 15) / 2 % 8], 1'h0};
      o_oe = 4'h2;
    end
    else if (busy == 0 && (l > 1 || op == SFC_SINGLE_LINE_DDR_READ))
    begin
      if (h >= 16 && h < a)
        ad = (ad << l) | 24'(i_io & (4'hf >> (4 - l)));
      if (j >= 0)
      begin
        by = 8'(ad[7:0] + 8'(j * l / 8)) >> (8 - l - j * l % 8);
        o_io = l == 1 ? {2'h0, by[0], 1'h0} : by[3:0];
        o_oe = l == 1 ? 4'h2 : l == 2 ? 4'h3 : 4'hf;
      end
    end
  end

  // Deselection ends output; write-type opcodes act only on an exact byte count.
  always @(posedge i_cs_n)
  begin
    o_oe = '0;
    if (op == SFC_READ_STATUS_CMD && busy > 0)
      busy = busy - 1;
    else if (op == SFC_SET_WRITE_LATCH_CMD && c == 8)
      write_enable_latch = 1'b1;
    else if (op == SFC_CLEAR_WRITE_LATCH_CMD && c == 8)
      write_enable_latch = 1'b0;
    else if (write_enable_latch && (op == SFC_WRITE_STATUS_CMD && c == 16 || (op == SFC_SECTOR_ERASE_CMD ||
             op == SFC_BLOCK_ERASE_CMD) && c == 32))
    begin
      if (op == SFC_WRITE_STATUS_CMD)
        sr = wd[7:2];
      write_enable_latch = 1'b0;
      busy = BUSYN;
    end
  end
endmodule

// ==== tb/sfc_host_tb_top.sv ====
/*
  Scenario bench for the serial flash command host facing a flash model.
  Assumes the four data lines carry pull-ups on the board.
*/
`timescale 1ns/1ps
module sfc_host_tb_top
  import sfc_pkg::*;
;
  localparam logic [23:0] ID = 24'h5a3c18; // Arbitrary identification value.
  logic       i_clk;
  logic       i_rst_n;
  logic       i_cmd_valid;
  logic       o_cmd_ready;
  sfc_cmd_t   i_cmd;
  logic       o_busy;
  logic       o_done;
  logic [7:0] o_status;
  logic       o_rd_valid;
  logic       i_rd_ready;
  logic [7:0] o_rd_data;
  logic       o_cs_n;
  logic       o_sclk;
  logic [3:0] o_io_out;
  logic [3:0] o_io_oe;
  logic [3:0] i_io_in;
  logic [3:0] f_io;
  logic [3:0] f_oe;
  logic       got_done;
  int         n_mismatch;
  int         comparisons;

  sfc_host #(.HALF_DIV(4), .CS_GAP(2), .DEPTH(32)) uut (.*);
  sfc_flash_model #(.ID(ID), .BUSYN(3)) u_flash (.i_cs_n(o_cs_n), .i_sclk(o_sclk), .i_io(i_io_in),
                                                 .o_io(f_io), .o_oe(f_oe));

  // Line levels: host drive, else flash drive, else pull-up.
  assign i_io_in = (o_io_oe & o_io_out) | (~o_io_oe & f_oe & f_io) | (~o_io_oe & ~f_oe);

  // Clock toggles every half period; completion pulses are latched.
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (o_done === 1'b1)
      got_done <= 1'b1;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (got_done !== 1'b1 && n < 20000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(got_done, 1'b1);
    got_done = 1'b0;
  endtask

  // Presents one request for one cycle; ready is high whenever idle.
  task automatic issue(input sfc_kind_t k, input logic m3, input logic pf, input logic [23:0] ad,
                       input logic [7:0] wd, input logic [15:0] nb, input logic w);
    @(negedge i_clk);
    i_cmd = '{k, m3, pf, ad, wd, nb};
    i_cmd_valid = 1'b1;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    if (w)
      wait_done();
  endtask

  // Waits for a read byte, compares it and pops it.
  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    while (o_rd_valid !== 1'b1 && n < 20000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(o_rd_data, e);
    i_rd_ready = 1'b1;
    @(negedge i_clk);
    i_rd_ready = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic t_latch();
    issue(SFC_K_SET_WEL, 1'b0, 1'b0, '0, '0, 16'h1, 1'b1);
    issue(SFC_K_STATUS, 1'b0, 1'b0, '0, '0, 16'h1, 1'b1);
    chk(o_status, 8'h02);
    pop(8'h02);
    issue(SFC_K_CLR_WEL, 1'b1, 1'b0, '0, '0, 16'h1, 1'b1);
    issue(SFC_K_STATUS, 1'b1, 1'b0, '0, '0, 16'h1, 1'b1);
    chk(o_status, 8'h00);
    pop(8'h00);
  endtask

  task automatic t_ident();
    issue(SFC_K_IDENT, 1'b0, 1'b0, '0, '0, 16'h0, 1'b1);
    pop(ID[23:16]);
    pop(ID[15:8]);
    pop(ID[7:0]);
  endtask

  task automatic t_write();
    issue(SFC_K_SET_WEL, 1'b0, 1'b0, '0, '0, 16'h1, 1'b1);
    issue(SFC_K_WR_STATUS, 1'b0, 1'b0, '0, 8'ha4, 16'h1, 1'b1);
    issue(SFC_K_STATUS, 1'b0, 1'b0, '0, '0, 16'h1, 1'b1);
    pop(8'ha5);
    issue(SFC_K_SET_WEL, 1'b0, 1'b1, '0, '0, 16'h1, 1'b1);
    chk(o_status, 8'ha4);
    issue(SFC_K_SECT_ERASE, 1'b1, 1'b1, 24'h001000, '0, 16'h1, 1'b1);
    issue(SFC_K_SET_WEL, 1'b0, 1'b1, '0, '0, 16'h1, 1'b1);
    issue(SFC_K_BLK_ERASE, 1'b0, 1'b0, 24'h010000, '0, 16'h1, 1'b1);
    issue(SFC_K_DDR1, 1'b0, 1'b0, 24'h000040, '0, 16'h2, 1'b1);
    pop(8'hff);
    pop(8'hff);
    issue(SFC_K_STATUS, 1'b0, 1'b0, '0, '0, 16'h1, 1'b1);
    chk(o_status, 8'ha5);
    pop(8'ha5);
  endtask

  // Reads in every double-rate mode; the first overfills the buffer while stalled.
  task automatic t_ddr();
    sfc_kind_t   ks [3] = '{SFC_K_DDR1, SFC_K_DDR2, SFC_K_DDR4};
    logic [15:0] nb;
    for (int i = 0; i < 3; i++)
    begin
      nb = i == 0 ? 16'd40 : 16'd5;
      issue(ks[i], i[0], 1'b1, 24'h1230f0 + 24'(i * 16), '0, nb, 1'b0);
      if (i == 0)
      begin
        repeat (2000) @(negedge i_clk);
        chk(o_busy, 1'b1);
      end
      for (int j = 0; j < 40 && j < nb; j++)
        pop(8'(8'hf0 + 8'(i * 16) + 8'(j)));
      wait_done();
    end
  endtask

  // Main sequence: reset, idle state, then every scenario.
  initial
  begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    i_rd_ready = 1'b0;
    got_done = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk({o_cs_n, o_io_oe, o_cmd_ready}, {1'b1, 4'hd, 1'b1});
    t_latch();
    t_ident();
    t_write();
    t_ddr();
    final_report();
  end

  // Watchdog: the scenarios need well under 30000 cycles.
  initial
  begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule
